// ===== logic/stff_formatter.sv
// telemetry frame formatter for the active seismic unit
`timescale 1ns/100ps
`include "stff_params.svh"

// Summary of operation
// - split byte samples over odd/even word nibbles
// - fifth bit of split subwords stays zero
// - mark code sent when prior frame had event
// - send word number of prior-frame event
// - send bit number of prior-frame event
// - mode identifier in top three bits only
// - shift assembled frame serially to modulator
// - converter result held in buffer before loading
// - per-subword source select drives shift register
// - sample high and low references each frame
// - sync pattern fills first ten bits
// - 32 words of four subwords, external bit clock
// - sync sits in word one subwords one, two
// - event data in words 29, 30, 31
// - mode identifier in word 32 subword one
module stff_formatter
    import stff_pkg::*;
#(
    parameter logic [9:0] SYNC_PATTERN = `STFF_SYNC_PATTERN,
    parameter logic [4:0] MARK_CODE    = `STFF_MARK_CODE
) (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       bit_clock_in,
    input  wire logic       rt_event_in,
    input  wire logic [2:0] mode_id_in,
    input  wire logic       conv_done_in,
    input  wire logic [7:0] conv_data_in,
    output logic            serial_data_out,
    output logic            bit_strobe_out,
    output logic            frame_start_out,
    output logic            conv_start_out,
    output logic [3:0]      conv_channel_out
);

    typedef struct packed {
        stff_pins_t  meta;
        stff_pins_t  sync;
        logic        bclk_prev;
        logic        ev_prev;
        logic        done_prev;
        stff_pos_t   pos;
        logic [4:0]  sub;
        logic        ser;
        logic        strobe;
        logic        fstart;
        logic        conv_start;
        logic [3:0]  chan;
        logic [7:0]  hold;
        logic [7:0]  hk;
        logic [7:0]  geo1;
        stff_event_t cap;
        stff_event_t rep;
        logic [2:0]  mode;
    } stff_state_t;

    // start parked on the last bit so the first bit clock opens word one
    localparam stff_state_t RESET_STATE = '{
        pos:     '{word: `STFF_LAST_WORD, sub: `STFF_LAST_SUB,
                   bit_idx: `STFF_LAST_BIT},
        default: '0
    };

    stff_state_t    s_q;
    stff_state_t    s_d;
    stff_pos_t      nxt;
    stff_pos_t      fol;
    stff_conv_req_t req;
    stff_event_t    cap_n;
    logic [4:0]     sub_new;
    logic           bit_en;
    logic           ev_edge;
    logic           done_edge;
    logic           wrap;

    stff_subword_mux #(
        .SYNC_PATTERN (SYNC_PATTERN),
        .MARK_CODE    (MARK_CODE)
    ) u_mux (
        .pos_in      (nxt),
        .hold_in     (s_q.hold),
        .hk_in       (s_q.hk),
        .geo1_in     (s_q.geo1),
        .report_in   (s_q.rep),
        .mode_in     (s_q.mode),
        .subword_out (sub_new)
    );

    always_comb begin
        s_d = s_q;
        // two-stage synchronisers on the bit clock, event, done and mode pins
        s_d.meta = '{bclk: bit_clock_in, event_req: rt_event_in,
                     done: conv_done_in, mode: mode_id_in};
        s_d.sync       = s_q.meta;
        s_d.bclk_prev  = s_q.sync.bclk;
        s_d.ev_prev    = s_q.sync.event_req;
        s_d.done_prev  = s_q.sync.done;
        s_d.strobe     = 1'b0;
        s_d.conv_start = 1'b0;

        bit_en    = s_q.sync.bclk & ~s_q.bclk_prev;
        ev_edge   = s_q.sync.event_req & ~s_q.ev_prev;
        done_edge = s_q.sync.done & ~s_q.done_prev;
        wrap      = bit_en && s_q.pos.word == `STFF_LAST_WORD &&
                    s_q.pos.sub == `STFF_LAST_SUB &&
                    s_q.pos.bit_idx == `STFF_LAST_BIT;

        nxt = stff_next_pos(s_q.pos);
        fol = nxt;
        fol.bit_idx = `STFF_LAST_BIT;
        fol = stff_next_pos(fol);
        req = stff_conv_target(fol);

        // data lines are read three edges after done rose, long settled
        if (done_edge) begin
            s_d.hold = conv_data_in;
        end

        // first event of the frame wins; later ones in it are ignored
        cap_n = s_q.cap;
        if (ev_edge && !s_q.cap.valid) begin
            cap_n = '{valid: 1'b1, word: s_q.pos.word,
                      bit_idx: stff_bit_in_word(s_q.pos)};
        end
        if (wrap) begin
            // an event on the last bit still lands in this report
            s_d.rep  = cap_n;
            s_d.cap  = '0;
            s_d.mode = s_q.sync.mode;
        end else begin
            s_d.cap = cap_n;
        end

        if (bit_en) begin
            s_d.pos    = nxt;
            s_d.strobe = 1'b1;
            s_d.fstart = nxt == '0;
            if (nxt.bit_idx == 3'h0) begin
                s_d.sub = sub_new;
                s_d.ser = sub_new[4];
                // order the conversion the following subword will need
                if (req.valid) begin
                    s_d.conv_start = 1'b1;
                    s_d.chan       = req.chan;
                end
                if (nxt.sub == 2'h0 && !nxt.word[0]) begin
                    s_d.hk = s_q.hold;
                end
                if (nxt.word == `STFF_G1_STORE_WORD && nxt.sub == 2'h1) begin
                    s_d.geo1 = s_q.hold;
                end
            end else begin
                s_d.ser = s_q.sub[3'h4 - nxt.bit_idx];
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_q <= RESET_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    assign serial_data_out  = s_q.ser;
    assign bit_strobe_out   = s_q.strobe;
    assign frame_start_out  = s_q.fstart;
    assign conv_start_out   = s_q.conv_start;
    assign conv_channel_out = s_q.chan;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    logic hk_sub0;
    assign hk_sub0 = s_q.pos.sub == 2'h0 &&
                     s_q.pos.word >= `STFF_HK_FIRST_WORD &&
                     s_q.pos.word <= `STFF_HK_LAST_WORD;

    AST_SPARE_BIT:
    assert property (hk_sub0 |-> s_q.sub[0] == 1'b0)
        else $error("spare bit of split subword not zero");

    AST_HK_SPLIT:
    assert property (hk_sub0 && s_q.pos.word[0] |->
                     s_q.sub[4:1] == s_q.hk[3:0])
        else $error("even word does not carry low nibble");

    // each half is checked over the whole subword that carries it
    AST_SYNC:
    assert property (s_q.pos.word == `STFF_SYNC_WORD &&
                     s_q.pos.sub == 2'h0 |->
                     s_q.sub == SYNC_PATTERN[9:5])
        else $error("frame sync upper half wrong");

    AST_SYNC_LOW:
    assert property (s_q.pos.word == `STFF_SYNC_WORD &&
                     s_q.pos.sub == 2'h1 |->
                     s_q.sub == SYNC_PATTERN[4:0])
        else $error("frame sync lower half wrong");

    AST_MARK:
    assert property (s_q.pos.word == `STFF_MARK_WORD &&
                     s_q.pos.sub == 2'h0 |->
                     s_q.sub == (s_q.rep.valid ? MARK_CODE : 5'h00))
        else $error("mark code subword wrong");

    AST_WORD_NUMBER:
    assert property (s_q.pos.word == `STFF_EVWORD_WORD &&
                     s_q.pos.sub == 2'h0 |-> s_q.sub == s_q.rep.word)
        else $error("event word number subword wrong");

    AST_BIT_NUMBER:
    assert property (s_q.pos.word == `STFF_EVBIT_WORD &&
                     s_q.pos.sub == 2'h0 |-> s_q.sub == s_q.rep.bit_idx)
        else $error("event bit number subword wrong");

    AST_MODE_ID:
    assert property (s_q.pos.word == `STFF_MODE_WORD &&
                     s_q.pos.sub == 2'h0 |-> s_q.sub == {s_q.mode, 2'b00})
        else $error("mode identifier subword wrong");

    AST_MSB_FIRST:
    assert property (s_q.strobe |->
                     s_q.ser == s_q.sub[3'h4 - s_q.pos.bit_idx])
        else $error("serial bit order wrong");

    AST_REPORT_HELD:
    assert property (!wrap |=> $stable(s_q.rep))
        else $error("event report changed inside a frame");

    AST_REPORT_CLEAR:
    assert property (wrap && !cap_n.valid |=> !s_q.rep.valid)
        else $error("event report not cleared");

    AST_FRAME_WRAP:
    assert property (wrap |=> s_q.pos == '0 && s_q.fstart && s_q.strobe)
        else $error("frame did not restart after word 32");

    AST_HIGH_REF:
    assert property (s_q.conv_start && s_q.pos.word == 5'h0F &&
                     s_q.pos.sub == 2'h3 |-> s_q.chan == `STFF_CH_HIGH_REF)
        else $error("high reference not sampled");

    AST_CONV_PULSE:
    assert property (s_q.conv_start |=> !s_q.conv_start)
        else $error("converter start longer than one cycle");

    AST_LOW_REF:
    assert property (s_q.conv_start && s_q.pos.word == 5'h11 &&
                     s_q.pos.sub == 2'h3 |-> s_q.chan == `STFF_CH_LOW_REF)
        else $error("low reference not sampled");

    AST_STROBE_PULSE:
    assert property (s_q.strobe |=> !s_q.strobe)
        else $error("bit strobe longer than one cycle");

    AST_BIT_PACED:
    assert property (s_q.strobe |-> $past(bit_en))
        else $error("bit sent without a bit clock edge");

    AST_FRAME_START:
    assert property (s_q.fstart |-> s_q.pos == '0)
        else $error("frame start outside first bit");

    AST_HK_UPPER:
    assert property (hk_sub0 && !s_q.pos.word[0] |->
                     s_q.sub[4:1] == s_q.hk[7:4])
        else $error("odd word does not carry high nibble");

    AST_GEO1_READ:
    assert property (s_q.pos.word == `STFF_G1_READ_WORD &&
                     s_q.pos.sub == 2'h0 |-> s_q.sub == s_q.geo1[7:3])
        else $error("stored first geophone sample not read out");

    AST_MODE_SPARE:
    assert property (s_q.pos.word == `STFF_MODE_WORD &&
                     s_q.pos.sub == 2'h0 |-> s_q.sub[1:0] == 2'b00)
        else $error("unused mode subword bits not zero");

    // a new conversion must not disturb a subword still being shifted
    AST_HOLD_BUFFER:
    assert property (!done_edge |=> $stable(s_q.hold))
        else $error("holding buffer changed without a conversion");

    AST_EVENT_CAPTURE:
    assert property (ev_edge && !s_q.cap.valid && !wrap |=>
                     s_q.cap.valid &&
                     s_q.cap.word == $past(s_q.pos.word))
        else $error("event position not latched");

    AST_EVENT_FIRST:
    assert property (s_q.cap.valid && !wrap |=> $stable(s_q.cap))
        else $error("later event replaced the first one");

    COV_FRAME: cover property (wrap);
    COV_EVENT: cover property (wrap && cap_n.valid);
    COV_CONV:  cover property (done_edge);
    COV_MARK:  cover property (s_q.pos.word == `STFF_MARK_WORD &&
                               s_q.rep.valid && s_q.strobe);

endmodule

// ===== logic/stff_params.svh
// frame layout, channel map and timing constants of the telemetry formatter
`ifndef STFF_PARAMS_SVH
`define STFF_PARAMS_SVH

// position limits (all zero-based: word 0 is telemetry word one)
`define STFF_LAST_BIT      3'h4
`define STFF_LAST_SUB      2'h3
`define STFF_LAST_WORD     5'h1F

// word assignments
`define STFF_SYNC_WORD     5'h00
`define STFF_G1_STORE_WORD 5'h00
`define STFF_G1_READ_WORD  5'h01
`define STFF_HK_FIRST_WORD 5'h02
`define STFF_HK_LAST_WORD  5'h1B
`define STFF_MARK_WORD     5'h1C
`define STFF_EVWORD_WORD   5'h1D
`define STFF_EVBIT_WORD    5'h1E
`define STFF_MODE_WORD     5'h1F

// converter channel map
`define STFF_CH_GEO1       4'h0
`define STFF_CH_GEO2       4'h1
`define STFF_CH_GEO3       4'h2
`define STFF_CH_HK_BASE    4'h3
`define STFF_CH_HIGH_REF   4'hA
`define STFF_CH_LOW_REF    4'hB

// pattern values
`define STFF_SYNC_PATTERN  10'h37A
`define STFF_MARK_CODE     5'h15

// timing: 20 MHz system clock, 10.6 kHz bit clock (10600 Hz)
`define STFF_CLK_HZ        32'h0131_2D00
`define STFF_BIT_RATE_HZ   32'h0000_2968
`define STFF_CLKS_PER_BIT  (`STFF_CLK_HZ / `STFF_BIT_RATE_HZ)

`endif

// ===== logic/stff_pkg.sv
// types and position helpers of the telemetry formatter
`include "stff_params.svh"
package stff_pkg;

    typedef struct packed {
        logic [4:0] word;
        logic [1:0] sub;
        logic [2:0] bit_idx;
    } stff_pos_t;

    typedef struct packed {
        logic       valid;
        logic [4:0] word;
        logic [4:0] bit_idx;
    } stff_event_t;

    typedef struct packed {
        logic       valid;
        logic [3:0] chan;
    } stff_conv_req_t;

    typedef struct packed {
        logic       bclk;
        logic       event_req;
        logic       done;
        logic [2:0] mode;
    } stff_pins_t;

    typedef enum logic [1:0] {
        STFF_SRC_CONV  = 2'b00,
        STFF_SRC_FRAME = 2'b01,
        STFF_SRC_HELD  = 2'b10,
        STFF_SRC_CTRL  = 2'b11
    } stff_src_t;

    function automatic stff_pos_t stff_next_pos(input stff_pos_t p);
        stff_pos_t n;
        n = p;
        if (p.bit_idx == `STFF_LAST_BIT) begin
            n.bit_idx = 3'h0;
            n.sub     = p.sub + 2'h1;
            if (p.sub == `STFF_LAST_SUB) begin
                n.word = p.word + 5'h01;
            end
        end else begin
            n.bit_idx = p.bit_idx + 3'h1;
        end
        return n;
    endfunction

    function automatic logic [4:0] stff_bit_in_word(input stff_pos_t p);
        return 5'({p.sub, 2'b00} + {3'h0, p.sub} + {2'h0, p.bit_idx});
    endfunction

    // which channel must be converted for the subword at position p
    function automatic stff_conv_req_t stff_conv_target(input stff_pos_t p);
        stff_conv_req_t r;
        r = '0;
        unique case (p.sub)
            2'h1: r = '{valid: 1'b1, chan: `STFF_CH_GEO1};
            2'h2: r = '{valid: 1'b1, chan: `STFF_CH_GEO2};
            2'h3: r = '{valid: 1'b1, chan: `STFF_CH_GEO3};
            2'h0: begin
                if (p.word >= `STFF_HK_FIRST_WORD &&
                    p.word <= `STFF_HK_LAST_WORD && !p.word[0]) begin
                    r.valid = 1'b1;
                    r.chan  = 4'(`STFF_CH_HK_BASE + p.word[4:1] - 4'h1);
                end
            end
        endcase
        return r;
    endfunction

endpackage

// ===== logic/stff_subword_mux.sv
// selects the five-bit subword for a frame position
`timescale 1ns/100ps
`include "stff_params.svh"
module stff_subword_mux
    import stff_pkg::*;
#(
    parameter logic [9:0] SYNC_PATTERN = `STFF_SYNC_PATTERN,
    parameter logic [4:0] MARK_CODE    = `STFF_MARK_CODE
) (
    input  wire stff_pos_t   pos_in,
    input  wire logic [7:0]  hold_in,
    input  wire logic [7:0]  hk_in,
    input  wire logic [7:0]  geo1_in,
    input  wire stff_event_t report_in,
    input  wire logic [2:0]  mode_in,
    output logic [4:0]       subword_out
);

    stff_src_t src;
    logic      hk_word;

    always_comb begin
        hk_word = pos_in.word >= `STFF_HK_FIRST_WORD &&
                  pos_in.word <= `STFF_HK_LAST_WORD;
        // source select per subword
        if (pos_in.word == `STFF_SYNC_WORD && pos_in.sub <= 2'h1) begin
            src = STFF_SRC_FRAME;
        end else if (pos_in.sub != 2'h0) begin
            src = STFF_SRC_CONV;
        end else if (pos_in.word == `STFF_G1_READ_WORD) begin
            src = STFF_SRC_HELD;
        end else if (hk_word) begin
            src = pos_in.word[0] ? STFF_SRC_HELD : STFF_SRC_CONV;
        end else begin
            src = STFF_SRC_CTRL;
        end
        unique case (src)
            STFF_SRC_CONV: begin
                // upper nibble of a housekeeping sample, fifth bit spare
                if (pos_in.sub == 2'h0) begin
                    subword_out = {hold_in[7:4], 1'b0};
                end else begin
                    subword_out = hold_in[7:3];
                end
            end
            STFF_SRC_FRAME: begin
                if (pos_in.sub == 2'h0) begin
                    subword_out = SYNC_PATTERN[9:5];
                end else begin
                    subword_out = SYNC_PATTERN[4:0];
                end
            end
            STFF_SRC_HELD: begin
                if (pos_in.word == `STFF_G1_READ_WORD) begin
                    subword_out = geo1_in[7:3];
                end else begin
                    subword_out = {hk_in[3:0], 1'b0};
                end
            end
            STFF_SRC_CTRL: begin
                if (pos_in.word == `STFF_MARK_WORD) begin
                    subword_out = report_in.valid ? MARK_CODE : 5'h00;
                end else if (pos_in.word == `STFF_EVWORD_WORD) begin
                    subword_out = report_in.word;
                end else if (pos_in.word == `STFF_EVBIT_WORD) begin
                    subword_out = report_in.bit_idx;
                end else begin
                    subword_out = {mode_in, 2'b00};
                end
            end
        endcase
    end

endmodule

// ===== dv/stff_modulator_model.sv
// bit clock source and serial frame capture standing in for the modulator
`timescale 1ns/100ps
module stff_modulator_model #(
    parameter int HALF = 8
) (
    input  wire logic   clk_in,
    input  wire logic   serial_in,
    input  wire logic   strobe_in,
    input  wire logic   frame_start_in,
    output logic        bit_clock_out,
    output logic [19:0] frame_q [32],
    output int          idx_q,
    output int          len_q,
    output int          frames_q
);
    logic [19:0] cur [32];

    // the square wave runs free; shortened so a run covers several frames
    initial begin
        bit_clock_out = 1'b0;
        forever begin
            repeat (HALF) @(negedge clk_in);
            bit_clock_out = ~bit_clock_out;
        end
    end

    initial begin
        idx_q = 0;
        len_q = 0;
        frames_q = 0;
    end

    always @(posedge clk_in) begin
        if (strobe_in) begin
            if (frame_start_in && idx_q != 0) begin
                frame_q = cur;
                len_q = idx_q;
                frames_q++;
                idx_q = 0;
            end
            if (idx_q < 640) begin
                cur[idx_q / 20][19 - idx_q % 20] = serial_in;
            end
            idx_q++;
        end
    end
endmodule

// ===== dv/seismic_telemetry_frame_formatter_test.sv
// self-checking bench of the telemetry frame formatter
`timescale 1ns/100ps
`include "stff_params.svh"
module seismic_telemetry_frame_formatter_test;
    logic        clk_in;
    logic        rst_in;
    logic        bit_clock;
    logic        rt_event_in;
    logic        conv_done_in;
    logic [2:0]  mode_id_in;
    logic [7:0]  conv_data_in;
    logic [3:0]  conv_ch;
    logic        serial;
    logic        strobe;
    logic        fstart;
    logic        conv_start;
    logic [3:0]  conv_channel;
    logic [19:0] frame_w [32];
    int          idx;
    int          len;
    int          frames;
    int          conv_cnt;
    int          cycles;
    int          failures;
    int          compares;

    stff_formatter stff_formatter_i (
        .clk_in           (clk_in),
        .rst_in           (rst_in),
        .bit_clock_in     (bit_clock),
        .rt_event_in      (rt_event_in),
        .mode_id_in       (mode_id_in),
        .conv_done_in     (conv_done_in),
        .conv_data_in     (conv_data_in),
        .serial_data_out  (serial),
        .bit_strobe_out   (strobe),
        .frame_start_out  (fstart),
        .conv_start_out   (conv_start),
        .conv_channel_out (conv_channel)
    );

    stff_modulator_model stff_modulator_model_i (
        .clk_in         (clk_in),
        .serial_in      (serial),
        .strobe_in      (strobe),
        .frame_start_in (fstart),
        .bit_clock_out  (bit_clock),
        .frame_q        (frame_w),
        .idx_q          (idx),
        .len_q          (len),
        .frames_q       (frames)
    );

    function automatic logic [7:0] cdat(input logic [3:0] ch);
        return {ch, ~ch} ^ 8'h3C;
    endfunction

    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    // converter: data valid three clocks from done, then scrambled
    always @(negedge clk_in) begin
        if (conv_start) begin
            conv_ch = conv_channel;
            conv_cnt = 5;
        end else if (conv_cnt > 0) begin
            conv_cnt--;
        end
        if (conv_cnt == 4) conv_data_in = cdat(conv_ch);
        if (conv_cnt == 1) conv_data_in = ~conv_data_in;
        conv_done_in = (conv_cnt >= 2 && conv_cnt <= 4);
    end

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            tally_and_finish();
        end
    end

    task automatic chk(input string name, input logic [19:0] exp,
                       input logic [19:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_frame(input logic [4:0] mk, input logic [4:0] ew,
                               input logic [4:0] eb, input logic [2:0] md);
        logic [19:0] e;
        logic [7:0]  g0;
        logic [7:0]  g1;
        logic [7:0]  g2;
        logic [7:0]  h;
        g0 = cdat(4'h0);
        g1 = cdat(4'h1);
        g2 = cdat(4'h2);
        for (int w = 0; w < 32; w++) begin
            e = {5'h00, g0[7:3], g1[7:3], g2[7:3]};
            h = cdat(4'(3 + (w - 2) / 2));
            if (w == 0) e[19:10] = `STFF_SYNC_PATTERN;
            else if (w == 1) e[19:15] = g0[7:3];
            else if (w < 28) e[19:15] = w[0] ? {h[3:0], 1'b0} : {h[7:4], 1'b0};
            else if (w == 28) e[19:15] = mk;
            else if (w == 29) e[19:15] = ew;
            else if (w == 30) e[19:15] = eb;
            else e[19:15] = {md, 2'b00};
            chk("word", e, frame_w[w]);
        end
        chk("bits", 20'h0_0280, 20'(len));
    endtask

    task automatic pulse_event;
        rt_event_in = 1'b1;
        repeat (4) @(negedge clk_in);
        rt_event_in = 1'b0;
    endtask

    // first event at word 7 bit 13, a later one in the same frame ignored
    task automatic scen_event_report;
        while (idx != 154) @(negedge clk_in);
        repeat (2) @(negedge clk_in);
        pulse_event();
        while (idx != 401) @(negedge clk_in);
        pulse_event();
        while (frames < 1) @(negedge clk_in);
        mode_id_in = 3'h2;
        while (frames < 2) @(negedge clk_in);
        check_frame(`STFF_MARK_CODE, 5'h07, 5'h0D, 3'h5);
        chk("mark", 20'(`STFF_MARK_CODE), 20'(frame_w[28][19:15]));
        chk("event word", 20'h0_0007, 20'(frame_w[29][19:15]));
        chk("event bit", 20'h0_000D, 20'(frame_w[30][19:15]));
    endtask

    // a frame without events reports nothing; new mode shows up
    task automatic scen_report_cleared;
        while (frames < 3) @(negedge clk_in);
        check_frame(5'h00, 5'h00, 5'h00, 3'h2);
        chk("mark clear", 20'h0_0000, 20'(frame_w[28][19:15]));
        chk("word clear", 20'h0_0000, 20'(frame_w[29][19:15]));
        chk("bit clear", 20'h0_0000, 20'(frame_w[30][19:15]));
    endtask

    task automatic tally_and_finish;
        if (failures == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        rst_in = 1'b1;
        rt_event_in = 1'b0;
        mode_id_in = 3'h5;
        conv_done_in = 1'b0;
        conv_data_in = 8'h00;
        conv_ch = 4'h0;
        conv_cnt = 0;
        cycles = 0;
        failures = 0;
        compares = 0;
        repeat (5) @(negedge clk_in);
        rst_in = 1'b0;
        scen_event_report();
        scen_report_cleared();
        tally_and_finish();
    end
endmodule
